/* indirect_load_accumulator.sv */
// Purpose: Executes the three indirect accumulator loads
// Assumes: Data space answers reads with a one-cycle ack on this clock
// Notes: Instructions are issued by writing the instruction register
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module indirect_load_accumulator (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output var ild_pkg::mem_req_type O_MEM,
  input wire ild_pkg::mem_rsp_type I_MEM,
  output logic [7:0] O_ACC,
  output logic [7:0] O_PSW,
  output logic [16:0] O_PC,
  output logic O_DONE
);

  ild_pkg::state_type state;
  ild_pkg::form_type form;
  ild_pkg::decode_type dec;
  logic [5:0] ptr_num;
  logic [6:0] off;
  logic [7:0] ptr_lo;
  logic [16:0] ptr_val;
  logic [16:0] ptr_now;
  logic [16:0] ea;
  logic [7:0] disp;
  logic [15:0] instr;
  logic illegal;
  logic [1:0] mcycle;
  logic [31:0] rd_value;
  logic [31:0] merged;
  logic wb_hit;
  logic wr;
  logic busy;
  logic start;
  logic start_ok;
  logic finish;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    lane_merge = res;
  endfunction

  assign wb_hit = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr = wb_hit && I_WB_WE;
  assign busy = (state != ild_pkg::S_IDLE);
  // Both low lanes must be written so opcode and operand arrive together
  assign start = wr && (I_WB_ADR == ild_pkg::REG_INSTR) &&
                 (I_WB_SEL[1:0] == 2'b11);
  assign start_ok = start && !busy && dec.legal;
  assign finish = (state == ild_pkg::S_DATA) && I_MEM.ack;
  assign merged = lane_merge(rd_value, I_WB_DAT, I_WB_SEL);

  // Missing ninth bit on the high byte reads as zero
  assign ptr_now = {I_MEM.has_bit8 & I_MEM.bit8, I_MEM.data, ptr_lo};

  ild_decoder u_decoder (
    .i_opcode(I_WB_DAT[15:8]),
    .i_operand(I_WB_DAT[7:0]),
    .o_dec(dec)
  );

  ild_ea u_ea (
    .i_ptr(ptr_now),
    .i_form(form),
    .i_disp(disp),
    .i_off(off),
    .o_ea(ea)
  );

  always_comb begin
    case (I_WB_ADR)
      ild_pkg::REG_INSTR: rd_value = {16'h0000, instr};
      ild_pkg::REG_ACC: rd_value = {24'h000000, O_ACC};
      ild_pkg::REG_DISP: rd_value = {24'h000000, disp};
      ild_pkg::REG_PSW: rd_value = {24'h000000, O_PSW};
      ild_pkg::REG_PC: rd_value = {15'h0000, O_PC};
      ild_pkg::REG_STATUS: rd_value = {26'h0000000, mcycle, form, illegal,
                                       busy};
      default: rd_value = 32'h00000000;
    endcase
  end

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else begin
      O_WB_ACK <= wb_hit;
      if (wb_hit && !I_WB_WE) begin
        O_WB_DAT <= rd_value;
      end
    end
  end

  // Sequencer: pointer fetch is the first machine cycle, data the second
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state <= ild_pkg::S_IDLE;
      O_MEM <= '0;
      form <= ild_pkg::FORM_PTR;
      ptr_num <= 6'h00;
      off <= 7'h00;
      ptr_lo <= 8'h00;
      ptr_val <= 17'h00000;
      mcycle <= 2'h0;
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      case (state)
        ild_pkg::S_IDLE: begin
          if (start_ok) begin
            form <= dec.form;
            ptr_num <= dec.ptr;
            off <= dec.off;
            O_MEM.rd <= 1'b1;
            O_MEM.addr <= ild_pkg::ptr_addr(dec.ptr, 1'b0);
            mcycle <= ild_pkg::MCYCLE_PTR;
            state <= ild_pkg::S_PTR_LO;
          end
        end
        ild_pkg::S_PTR_LO: begin
          if (I_MEM.ack) begin
            ptr_lo <= I_MEM.data;
            O_MEM.addr <= ild_pkg::ptr_addr(ptr_num, 1'b1);
            state <= ild_pkg::S_PTR_HI;
          end
        end
        ild_pkg::S_PTR_HI: begin
          if (I_MEM.ack) begin
            ptr_val <= ptr_now;
            O_MEM.addr <= ea;
            mcycle <= ild_pkg::MCYCLE_DATA;
            state <= ild_pkg::S_DATA;
          end
        end
        ild_pkg::S_DATA: begin
          if (I_MEM.ack) begin
            O_MEM.rd <= 1'b0;
            O_DONE <= 1'b1;
            mcycle <= 2'h0;
            state <= ild_pkg::S_IDLE;
          end
        end
        default: begin
          O_MEM.rd <= 1'b0;
          state <= ild_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Architectural registers; software writes are refused while busy
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_ACC <= ild_pkg::ACC_RST;
      O_PSW <= ild_pkg::PSW_RST;
      O_PC <= ild_pkg::PC_RST;
      disp <= ild_pkg::DISP_RST;
    end else if (finish) begin
      O_ACC <= I_MEM.data;
      if (I_MEM.has_bit8) begin
        O_PSW[ild_pkg::PSW_NINTH_BIT] <= I_MEM.bit8;
      end
      O_PC <= O_PC + ild_pkg::PC_STEP;
    end else if (wr && !busy) begin
      case (I_WB_ADR)
        ild_pkg::REG_ACC: O_ACC <= merged[7:0];
        ild_pkg::REG_DISP: disp <= merged[7:0];
        ild_pkg::REG_PSW: O_PSW <= merged[7:0];
        ild_pkg::REG_PC: O_PC <= merged[16:0];
        default: O_ACC <= O_ACC;
      endcase
    end
  end

  // Instruction latch and sticky illegal-opcode flag
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      instr <= ild_pkg::INSTR_RST;
      illegal <= 1'b0;
    end else begin
      if (start && !busy) begin
        instr <= I_WB_DAT[15:0];
      end
      // A fresh illegal opcode outranks a same-cycle clear
      if (start && !busy && !dec.legal) begin
        illegal <= 1'b1;
      end else if (wr && I_WB_ADR == ild_pkg::REG_STATUS && I_WB_SEL[0] &&
                   I_WB_DAT[ild_pkg::ST_ILLEGAL]) begin
        illegal <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  decode_start_a: assert property (
    start && !busy && I_WB_DAT[15:8] == ild_pkg::OPC_LOAD_IND
    |=> state == ild_pkg::S_PTR_LO && O_MEM.rd &&
        form == ($past(I_WB_DAT[7]) ? ild_pkg::FORM_OFFSET :
                 ($past(I_WB_DAT[0]) ? ild_pkg::FORM_PTR_DISP :
                  ild_pkg::FORM_PTR))
        && ptr_num == ($past(I_WB_DAT[7]) ? 6'h00 : $past(I_WB_DAT[6:1])))
    else $error("Indirect load not started as decoded");

  illegal_op_a: assert property (
    start && !busy && I_WB_DAT[15:8] != ild_pkg::OPC_LOAD_IND
    |=> illegal && state == ild_pkg::S_IDLE)
    else $error("Foreign opcode was executed");

  ptr_lo_addr_a: assert property (
    state == ild_pkg::S_PTR_LO |-> O_MEM.rd &&
    O_MEM.addr == {10'h000, ptr_num, 1'b0})
    else $error("Pointer low byte fetched from wrong address");

  ptr_hi_addr_a: assert property (
    state == ild_pkg::S_PTR_HI |-> O_MEM.rd &&
    O_MEM.addr == {10'h000, ptr_num, 1'b1})
    else $error("Pointer high byte fetched from wrong address");

  plain_ea_a: assert property (
    state == ild_pkg::S_DATA && form == ild_pkg::FORM_PTR
    |-> O_MEM.addr == ptr_val)
    else $error("Plain pointer address wrong");

  disp_ea_a: assert property (
    state == ild_pkg::S_DATA && form == ild_pkg::FORM_PTR_DISP
    |-> O_MEM.addr == 17'(ptr_val + {{9{disp[7]}}, disp}))
    else $error("Displacement address wrong");

  off_ea_a: assert property (
    state == ild_pkg::S_DATA && form == ild_pkg::FORM_OFFSET
    |-> ptr_num == 6'h00 && O_MEM.addr == 17'(ptr_val + {{10{off[6]}}, off}))
    else $error("Offset address wrong");

  acc_load_a: assert property (
    finish |=> O_ACC == $past(I_MEM.data) && O_DONE &&
               O_PC == 17'($past(O_PC) + 17'h00002) &&
               state == ild_pkg::S_IDLE)
    else $error("Load did not complete properly");

  ninth_copy_a: assert property (
    finish && I_MEM.has_bit8 |=> O_PSW[1] == $past(I_MEM.bit8))
    else $error("Ninth bit not copied");

  psw_keep_a: assert property (
    finish |=> (O_PSW & 8'hFD) == ($past(O_PSW) & 8'hFD) &&
               disp == $past(disp) &&
               ($past(I_MEM.has_bit8) || O_PSW == $past(O_PSW)))
    else $error("Unrelated state changed by a load");

  mcycle_a: assert property (
    $rose(state == ild_pkg::S_DATA) |-> mcycle == 2'h2 &&
    $past(mcycle) == 2'h1)
    else $error("Machine cycle count wrong");

  mcycle_ptr_a: assert property (
    state == ild_pkg::S_PTR_LO || state == ild_pkg::S_PTR_HI
    |-> mcycle == ild_pkg::MCYCLE_PTR)
    else $error("Pointer fetch outside first machine cycle");

  ptr_high_a: assert property (
    state == ild_pkg::S_PTR_HI && I_MEM.ack
    |=> ptr_val == {$past(I_MEM.bit8) & $past(I_MEM.has_bit8),
                    $past(I_MEM.data), $past(ptr_lo)})
    else $error("Pointer not assembled from both bytes");

  done_pulse_a: assert property (
    O_DONE |-> state == ild_pkg::S_IDLE && !O_MEM.rd && mcycle == 2'h0
    ##1 !O_DONE)
    else $error("Completion pulse or idle state wrong");

  // Loads must not disturb anything but ACC, PSW bit 1 and PC
  busy_hold_a: assert property (
    busy && !finish |=> $stable(O_ACC) && $stable(O_PSW) &&
    $stable(O_PC) && $stable(disp))
    else $error("Register changed while a load was running");

  idle_hold_a: assert property (
    !busy && !wr |=> $stable(O_ACC) && $stable(O_PSW) && $stable(O_PC))
    else $error("Register changed with no load or write");

  // Bus slave answers every request one cycle later, for one cycle
  ack_pulse_a: assert property (
    O_WB_ACK |=> !O_WB_ACK)
    else $error("Bus ack longer than one cycle");

  ack_time_a: assert property (
    I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("Bus request not acked in one cycle");

  acc_read_a: assert property (
    wb_hit && !I_WB_WE && I_WB_ADR == ild_pkg::REG_ACC
    |=> O_WB_DAT == {24'h000000, $past(O_ACC)})
    else $error("Accumulator read back wrong");

  status_read_a: assert property (
    wb_hit && !I_WB_WE && I_WB_ADR == ild_pkg::REG_STATUS
    |=> O_WB_DAT[ild_pkg::ST_BUSY] == $past(busy) &&
        O_WB_DAT[ild_pkg::ST_ILLEGAL] == $past(illegal) &&
        O_WB_DAT[5:4] == $past(mcycle))
    else $error("Status word read back wrong");

  busy_write_c: cover property (wr && busy);
  plain_done_c: cover property (finish && form == ild_pkg::FORM_PTR);
  disp_done_c: cover property (finish && form == ild_pkg::FORM_PTR_DISP);
  off_done_c: cover property (finish && form == ild_pkg::FORM_OFFSET);
  illegal_c: cover property (start && !busy && !dec.legal);

endmodule
`default_nettype wire

/* ild_pkg.sv */
// Purpose: Shared constants, types and helpers for the indirect load unit
// Assumes: 17-bit data-space addresses, 9-bit data words
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus
`default_nettype none
package ild_pkg;

  localparam logic [7:0] OPC_LOAD_IND = 8'h82;
  localparam int unsigned OPND_MODE_BIT = 7;
  localparam int unsigned OPND_CREG_BIT = 0;
  localparam int unsigned OPND_PTR_MSB = 6;
  localparam int unsigned OPND_PTR_LSB = 1;
  localparam int unsigned PSW_NINTH_BIT = 1;

  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_DISP = 8'h08;
  localparam logic [7:0] REG_PSW = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_ILLEGAL = 1;
  localparam int unsigned ST_FORM_LSB = 2;
  localparam int unsigned ST_MCYCLE_LSB = 4;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DISP_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [16:0] PC_RST = 17'h00000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [16:0] PC_STEP = 17'h00002;
  localparam logic [1:0] MCYCLE_PTR = 2'h1;
  localparam logic [1:0] MCYCLE_DATA = 2'h2;

  typedef enum logic [1:0] {
    FORM_PTR = 2'h0,
    FORM_PTR_DISP = 2'h1,
    FORM_OFFSET = 2'h2
  } form_type;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PTR_LO = 4'b0010,
    S_PTR_HI = 4'b0100,
    S_DATA = 4'b1000
  } state_type;

  typedef struct packed {
    logic rd;
    logic [16:0] addr;
  } mem_req_type;

  typedef struct packed {
    logic ack;
    logic [7:0] data;
    logic bit8;
    logic has_bit8;
  } mem_rsp_type;

  typedef struct packed {
    logic legal;
    form_type form;
    logic [5:0] ptr;
    logic [6:0] off;
  } decode_type;

  function automatic logic [16:0] sext17(input logic [7:0] v);
    sext17 = {{9{v[7]}}, v};
  endfunction

  function automatic logic [16:0] ptr_addr(input logic [5:0] num,
                                          input logic hi);
    ptr_addr = {10'h000, num, hi};
  endfunction

endpackage
`default_nettype wire

/* ild_decoder.sv */
// Purpose: Splits the two instruction bytes into form, pointer and offset
// Assumes: Only the indirect accumulator loads are recognised here
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module ild_decoder (
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand,
  output var ild_pkg::decode_type o_dec
);
  always_comb begin
    o_dec.legal = (i_opcode == ild_pkg::OPC_LOAD_IND);
    o_dec.off = i_operand[6:0];
    if (i_operand[ild_pkg::OPND_MODE_BIT]) begin
      // Offset form always works from pointer pair zero
      o_dec.form = ild_pkg::FORM_OFFSET;
      o_dec.ptr = 6'h00;
    end else begin
      // Bit 0 picks plain pointer or pointer plus displacement
      o_dec.form = i_operand[ild_pkg::OPND_CREG_BIT] ?
                   ild_pkg::FORM_PTR_DISP : ild_pkg::FORM_PTR;
      o_dec.ptr = i_operand[ild_pkg::OPND_PTR_MSB:ild_pkg::OPND_PTR_LSB];
    end
  end
endmodule
`default_nettype wire

/* ild_ea.sv */
// Purpose: Effective address of an indirect load
// Assumes: Pointer already assembled as 17 bits
// Notes: Sums wrap modulo 2^17
`timescale 1ns/1ps
`default_nettype none
module ild_ea (
  input wire logic [16:0] i_ptr,
  input wire ild_pkg::form_type i_form,
  input wire logic [7:0] i_disp,
  input wire logic [6:0] i_off,
  output logic [16:0] o_ea
);
  always_comb begin
    case (i_form)
      ild_pkg::FORM_PTR: o_ea = i_ptr;
      // Displacement is signed, -128..127
      ild_pkg::FORM_PTR_DISP: o_ea = i_ptr + ild_pkg::sext17(i_disp);
      // Offset is signed, -64..63
      ild_pkg::FORM_OFFSET: o_ea = i_ptr + ild_pkg::sext17({i_off[6], i_off});
      default: o_ea = i_ptr;
    endcase
  end
endmodule
`default_nettype wire

/* ild_mem_model.sv */
// Purpose: Data-space model answering the indirect load unit's reads
// Assumes: 256 locations aliased over the 17-bit space; C0-FF lack a ninth bit
// Notes: Ack delay is set by the bench; idle lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module ild_mem_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ild_pkg::mem_req_type i_req,
  input wire logic [1:0] i_delay,
  output var ild_pkg::mem_rsp_type o_rsp
);
  logic [8:0] mem [0:255];
  logic [16:0] last_addr;
  logic [8:0] last;
  logic [1:0] wait_cnt;
  logic ack;
  logic hb;

  // Ninth bit exists only below C0H so both cases get exercised
  assign hb = (last_addr[7:6] != 2'b11);
  // Inverted lines outside ack keep stale data from looking valid
  assign o_rsp = ack ? {1'b1, last[7:0], last[8] & hb, hb}
                     : {1'b0, ~last[7:0], ~last[8], ~hb};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      wait_cnt <= 2'h0;
      last <= 9'h000;
      last_addr <= 17'h00000;
    end else if (ack) begin
      ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (i_req.rd) begin
      if (wait_cnt == i_delay) begin
        ack <= 1'b1;
        last <= mem[i_req.addr[7:0]];
        last_addr <= i_req.addr;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* ild_tb.sv */
// Purpose: Self-checking bench for the indirect accumulator loads
// Assumes: Registers reached over classic Wishbone, one-cycle ack
// Notes: Expected addresses are checked against the model's last read address
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] d;
  logic ack;
  logic done;
  ild_pkg::mem_req_type req;
  ild_pkg::mem_rsp_type rsp;
  logic [7:0] acc;
  logic [7:0] psw;
  logic [16:0] pc;
  logic [1:0] mem_delay = 2'h0;
  logic [7:0] exp_psw = 8'h00;
  logic [16:0] exp_pc = 17'h00000;
  int miscompares = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  indirect_load_accumulator indirect_load_accumulator_i (.I_CLOCK(clk),
    .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_MEM(req), .I_MEM(rsp), .O_ACC(acc), .O_PSW(psw),
    .O_PC(pc), .O_DONE(done));
  ild_mem_model ild_mem_model_i (.i_clk(clk), .i_rst(rst), .i_req(req),
    .i_delay(mem_delay), .o_rsp(rsp));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] wd, input logic [3:0] s,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= wd;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd,
                    input logic [3:0] s);
    logic [31:0] unused;
    wb_cycle(1'b1, a, wd, s, unused);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    wb_cycle(1'b0, a, 32'h00000000, 4'hF, v);
    check(v, exp);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask

  task automatic run_load(input logic [15:0] ins, input logic [16:0] ea,
                          input logic [7:0] exp_acc);
    wr(ild_pkg::REG_INSTR, {16'h0000, ins}, 4'hF);
    wait_done();
    exp_pc = exp_pc + ild_pkg::PC_STEP;
    check({24'h000000, acc}, {24'h000000, exp_acc});
    check({24'h000000, psw}, {24'h000000, exp_psw});
    check({15'h0000, pc}, {15'h0000, exp_pc});
    rd_check(ild_pkg::REG_ACC, {24'h000000, exp_acc});
    rd_check(ild_pkg::REG_PSW, {24'h000000, exp_psw});
    rd_check(ild_pkg::REG_PC, {15'h0000, exp_pc});
    check({15'h0000, ild_mem_model_i.last_addr}, {15'h0000, ea});
  endtask

  task automatic s_reset();
    rd_check(ild_pkg::REG_ACC, 32'h00000000);
    rd_check(ild_pkg::REG_PSW, 32'h00000000);
    rd_check(ild_pkg::REG_PC, 32'h00000000);
    rd_check(ild_pkg::REG_DISP, 32'h00000000);
    rd_check(ild_pkg::REG_INSTR, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF, 4'hF);
    rd_check(8'h20, 32'h00000000);
  endtask

  task automatic s_plain();
    wr(ild_pkg::REG_PSW, 32'h000000A5, 4'h1);
    exp_psw = 8'hA7;
    run_load(16'h8202, 17'h00051, 8'hFF);
  endtask

  task automatic s_ptr63();
    // Slow answers; high byte ninth bit lifts pointer bit 16
    mem_delay <= 2'h3;
    run_load(16'h827E, 17'h101D0, 8'hAB);
    mem_delay <= 2'h0;
  endtask

  task automatic s_disp();
    wr(ild_pkg::REG_DISP, 32'h000000FB, 4'h1);
    exp_psw = 8'hA5;
    run_load(16'h8203, 17'h0004C, 8'h88);
    rd_check(ild_pkg::REG_DISP, 32'h000000FB);
  endtask

  task automatic s_offset();
    exp_psw = 8'hA7;
    run_load(16'h8285, 17'h00056, 8'h00);
    exp_psw = 8'hA5;
    run_load(16'h82C0, 17'h00011, 8'h77);
  endtask

  task automatic s_illegal();
    wr(ild_pkg::REG_INSTR, 32'h00008302, 4'hF);
    repeat (10) @(posedge clk);
    rd_check(ild_pkg::REG_ACC, 32'h00000077);
    rd_check(ild_pkg::REG_PC, {15'h0000, exp_pc});
    wb_cycle(1'b0, ild_pkg::REG_STATUS, 32'h00000000, 4'hF, d);
    check(d & 32'h00000002, 32'h00000002);
    wr(ild_pkg::REG_STATUS, 32'h00000002, 4'h1);
    wb_cycle(1'b0, ild_pkg::REG_STATUS, 32'h00000000, 4'hF, d);
    check(d & 32'h00000002, 32'h00000000);
  endtask

  task automatic s_busy();
    // Slow memory keeps the load running while software pokes at it
    mem_delay <= 2'h3;
    wr(ild_pkg::REG_INSTR, 32'h00008203, 4'hF);
    rd_check(ild_pkg::REG_STATUS, 32'h00000015);
    wr(ild_pkg::REG_ACC, 32'h0000005A, 4'h1);
    wr(ild_pkg::REG_INSTR, 32'h00008285, 4'hF);
    wait_done();
    mem_delay <= 2'h0;
    exp_pc = exp_pc + ild_pkg::PC_STEP;
    rd_check(ild_pkg::REG_ACC, 32'h00000088);
    rd_check(ild_pkg::REG_PSW, {24'h000000, exp_psw});
    rd_check(ild_pkg::REG_INSTR, 32'h00008203);
    rd_check(ild_pkg::REG_PC, {15'h0000, exp_pc});
  endtask

  initial begin
    ild_mem_model_i.mem[8'h00] = 9'h051;
    ild_mem_model_i.mem[8'h01] = 9'h000;
    ild_mem_model_i.mem[8'h02] = 9'h051;
    ild_mem_model_i.mem[8'h03] = 9'h000;
    ild_mem_model_i.mem[8'h51] = 9'h1FF;
    ild_mem_model_i.mem[8'h4C] = 9'h088;
    ild_mem_model_i.mem[8'h56] = 9'h100;
    ild_mem_model_i.mem[8'h11] = 9'h077;
    ild_mem_model_i.mem[8'h7E] = 9'h0D0;
    ild_mem_model_i.mem[8'h7F] = 9'h101;
    ild_mem_model_i.mem[8'hD0] = 9'h1AB;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_plain();
    s_ptr63();
    s_disp();
    s_offset();
    s_illegal();
    s_busy();
    end_of_test();
  end
endmodule
`default_nettype wire
